//--- bench/adc_ctrl_props.sv
// port checker of the converter control block
// assumes it is bound onto the block's top module, one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_consts.svh"

module adc_ctrl_props
   import adc_ctrl_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register port
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_rdata,
   // converter side
   input wire logic [9:0] conv_result,
   input wire logic conv_done,
   input wire logic conv_active,
   input wire logic window_flag_clear,
   input wire logic window_match_flag,
   input wire logic window_inside_mode,
   // selects
   input wire logic [7:0] port0_input_sel,
   input wire logic [7:0] port1_input_sel,
   input wire logic temp_input_sel,
   input wire logic vreg_input_sel,
   input wire logic vdd_input_sel,
   input wire logic gnd_input_sel,
   input wire logic vref_pin_sel,
   input wire logic vref_vdd_sel,
   input wire logic vref_core_sel,
   input wire logic vref_hs_sel,
   input wire logic hs_ref_enable,
   input wire logic agnd_pin_sel,
   input wire logic temp_sensor_on,
   input wire logic bias_enable
);
   logic [4:0] code_sh;
   logic [15:0] gt_sh;
   logic [15:0] lt_sh;
   logic [5:1] ref_sh;
   logic [7:0] rd_exp;
   logic [15:0] w;
   logic hit;
   logic cons;

   // ------------------------------------------------------------------
   // shadow of the register file
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         code_sh <= 5'h1f;
         gt_sh <= 16'hffff;
         lt_sh <= 16'h0000;
         ref_sh <= 5'h08;
      end
      else if (sfr_wr)
      begin
         case (sfr_addr)
            `ADDR_INPUT_SELECT: code_sh <= sfr_wdata[4:0];
            `ADDR_GT_LOW: gt_sh[7:0] <= sfr_wdata;
            `ADDR_GT_HIGH: gt_sh[15:8] <= sfr_wdata;
            `ADDR_LT_LOW: lt_sh[7:0] <= sfr_wdata;
            `ADDR_LT_HIGH: lt_sh[15:8] <= sfr_wdata;
            `ADDR_REFERENCE: ref_sh <= sfr_wdata[5:1];
            default: ;
         endcase
      end
   end

   always_comb
   begin
      case (sfr_addr)
         `ADDR_INPUT_SELECT: rd_exp = {3'h0, code_sh};
         `ADDR_GT_LOW: rd_exp = gt_sh[7:0];
         `ADDR_GT_HIGH: rd_exp = gt_sh[15:8];
         `ADDR_LT_LOW: rd_exp = lt_sh[7:0];
         `ADDR_LT_HIGH: rd_exp = lt_sh[15:8];
         `ADDR_REFERENCE: rd_exp = {2'h0, ref_sh, 1'b0};
         default: rd_exp = 8'h00;
      endcase
   end

   assign w = {6'h00, conv_result};
   assign hit = window_inside_mode ? (w > gt_sh && w < lt_sh) : (w < gt_sh || w > lt_sh);
   // flag checks only where the mode already reflects the limits
   assign cons = window_inside_mode == (lt_sh > gt_sh);

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // ------------------------------------------------------------------
   // properties
   // ------------------------------------------------------------------
   a_read_back_value: assert property (sfr_rd |=> sfr_rdata == $past(rd_exp))
      else $error("read data differs from register contents");
   a_mode_from_limits: assert property (window_inside_mode == $past(lt_sh > gt_sh))
      else $error("window mode does not follow limits");
   a_flag_sets_match: assert property (cons && conv_done && hit |=> window_match_flag)
      else $error("match did not raise window flag");
   a_flag_holds_still: assert property (cons && !(conv_done && hit) && !window_flag_clear
      |=> $stable(window_match_flag))
      else $error("window flag changed without cause");
   a_flag_clear_drops: assert property (cons && window_flag_clear && !(conv_done && hit)
      |=> !window_match_flag)
      else $error("window flag not cleared");
   a_port_pin_select: assert property ($past(rst_n) |-> {port1_input_sel, port0_input_sel} ==
      (($past(code_sh) < 5'h10) ? 16'h0001 << $past(code_sh) : 16'h0000))
      else $error("port pin select wrong");
   a_inner_node_select: assert property ($past(rst_n) |-> {gnd_input_sel, vdd_input_sel, vreg_input_sel,
      temp_input_sel} == (($past(code_sh[4:2]) == 3'h4) ? 4'h1 << $past(code_sh[1:0]) : 4'h0))
      else $error("internal node select wrong");
   a_vref_one_hot: assert property ($past(rst_n) |-> {vref_hs_sel, vref_core_sel, vref_vdd_sel, vref_pin_sel}
      == 4'h1 << $past(ref_sh[4:3]))
      else $error("voltage reference select wrong");
   a_ref_bits_follow: assert property ($past(rst_n) |-> {agnd_pin_sel, temp_sensor_on, bias_enable}
      == $past({ref_sh[5], ref_sh[2:1]}))
      else $error("ground or sensor enable wrong");
   a_hs_ref_gated: assert property (hs_ref_enable == $past(ref_sh[4:3] == 2'h3 && conv_active))
      else $error("fast reference enable wrong");

   c_inside_hit: cover property (conv_done && hit && window_inside_mode);
   c_outside_hit: cover property (conv_done && hit && !window_inside_mode);
   c_flag_cleared: cover property (window_flag_clear && window_match_flag);
   c_hs_ref_on: cover property (hs_ref_enable);
endmodule : adc_ctrl_props

bind adc_window_mux_reference_ctrl adc_ctrl_props i_props (.*);

`default_nettype wire

//--- bench/testbench.sv
// self-checking bench of the converter control block
// assumes the checker is bound onto the block; drives every input itself
`timescale 1ns/1ps
`default_nettype none

module testbench
   import adc_ctrl_pkg::*;
;
   logic clk, rst_n, sfr_wr, sfr_rd, conv_done, conv_active, window_flag_clear;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, port0_input_sel, port1_input_sel;
   logic [9:0] conv_result;
   logic window_match_flag, window_inside_mode, temp_input_sel, vreg_input_sel, vdd_input_sel, gnd_input_sel;
   logic vref_pin_sel, vref_vdd_sel, vref_core_sel, vref_hs_sel, hs_ref_enable, agnd_pin_sel;
   logic temp_sensor_on, bias_enable;
   int n_errors, checked, cycles;
   logic [7:0] ra [7] = '{8'hbb, 8'hc3, 8'hc4, 8'hc5, 8'hc6, 8'hd2, 8'hc7};
   logic [7:0] rv [7] = '{8'h1f, 8'hff, 8'hff, 8'h00, 8'h00, 8'h10, 8'h00};
   logic [9:0] wv [5] = '{10'h040, 10'h041, 10'h07f, 10'h080, 10'h3ff};

   adc_window_mux_reference_ctrl i_dut (.*);

   // ------------------------------------------------------------------
   // access tasks
   // ------------------------------------------------------------------
   task automatic chk(input string name, input logic [19:0] exp, input logic [19:0] got);
      checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value %s: expected %h, seen %h", name, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clk);
      sfr_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge clk);
      sfr_rd <= 1'b0;
      #1;
      chk("read data", e, sfr_rdata);
   endtask : rd

   task automatic setlim(input logic [15:0] gt, input logic [15:0] lt, input logic m);
      wr(8'hc3, gt[7:0]);
      wr(8'hc4, gt[15:8]);
      wr(8'hc5, lt[7:0]);
      wr(8'hc6, lt[15:8]);
      repeat (2) @(posedge clk);
      #1;
      chk("mode", m, window_inside_mode);
   endtask : setlim

   // clear afterwards unless the flag is meant to stay
   task automatic conv(input logic [9:0] v, input logic e, input logic clr);
      @(posedge clk);
      conv_result <= v;
      conv_done <= 1'b1;
      @(posedge clk);
      conv_done <= 1'b0;
      #1;
      chk("flag", e, window_match_flag);
      if (clr)
      begin
         @(posedge clk);
         window_flag_clear <= 1'b1;
         @(posedge clk);
         window_flag_clear <= 1'b0;
      end
   endtask : conv

   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_of_test

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // run needs about 280 cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_errors++;
         end_of_test();
      end
   end

   // ------------------------------------------------------------------
   // sequence
   // ------------------------------------------------------------------
   initial
   begin
      {rst_n, sfr_wr, sfr_rd, conv_done, conv_active, window_flag_clear} = '0;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      conv_result = 10'h000;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 7; i++)
         rd(ra[i], rv[i]);
      chk("vref", 4'h4, {vref_hs_sel, vref_core_sel, vref_vdd_sel, vref_pin_sel});
      // pins are made analog and crossbar-skipped by port setup outside this block
      for (int c = 0; c < 32; c++)
      begin
         wr(8'hbb, {3'h7, c[4:0]});
         rd(8'hbb, {3'h0, c[4:0]});
         chk("mux", (c < 20) ? 20'h1 << c : 20'h0, {gnd_input_sel, vdd_input_sel, vreg_input_sel,
            temp_input_sel, port1_input_sel, port0_input_sel});
      end
      for (int r = 0; r < 4; r++)
      begin
         wr(8'hd2, {2'h3, r[0], r[1:0], r[1], r[0], 1'b1});
         rd(8'hd2, {2'h0, r[0], r[1:0], r[1], r[0], 1'b0});
         chk("vref", 4'h1 << r, {vref_hs_sel, vref_core_sel, vref_vdd_sel, vref_pin_sel});
         chk("bits", {r[0], r[1], r[0]}, {agnd_pin_sel, temp_sensor_on, bias_enable});
         @(posedge clk);
         conv_active <= 1'b1;
         @(posedge clk);
         #1;
         chk("hs ref", r == 3, hs_ref_enable);
         @(posedge clk);
         conv_active <= 1'b0;
         @(posedge clk);
         #1;
         chk("hs ref", 1'b0, hs_ref_enable);
      end
      setlim(16'h0040, 16'h0080, 1'b1);
      for (int i = 0; i < 5; i++)
         conv(wv[i], i == 1 || i == 2, 1'b1);
      conv(10'h050, 1'b1, 1'b0);
      conv(10'h000, 1'b1, 1'b1);
      @(posedge clk);
      conv_result <= 10'h050;
      conv_done <= 1'b1;
      window_flag_clear <= 1'b1;
      @(posedge clk);
      conv_done <= 1'b0;
      window_flag_clear <= 1'b0;
      #1;
      chk("set over clear", 1'b1, window_match_flag);
      conv(10'h3ff, 1'b1, 1'b1);
      setlim(16'h0080, 16'h0080, 1'b0);
      conv(10'h080, 1'b0, 1'b1);
      conv(10'h07f, 1'b1, 1'b1);
      conv(10'h081, 1'b1, 1'b1);
      setlim(16'h03fe, 16'h0400, 1'b1);
      conv(10'h3ff, 1'b1, 1'b1);
      conv(10'h3fe, 1'b0, 1'b1);
      end_of_test();
   end
endmodule : testbench

`default_nettype wire

//--- hdl/adc_ctrl_consts.svh
// register addresses, field positions, reset values and mux codes of the
// converter control block; assumes an 8-bit special-function-register space
`ifndef ADC_CTRL_CONSTS_SVH
`define ADC_CTRL_CONSTS_SVH

// ----------------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------------
`define ADDR_INPUT_SELECT 8'hbb
`define ADDR_GT_LOW 8'hc3
`define ADDR_GT_HIGH 8'hc4
`define ADDR_LT_LOW 8'hc5
`define ADDR_LT_HIGH 8'hc6
`define ADDR_REFERENCE 8'hd2

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define RESET_INPUT_CODE 5'h1f
`define RESET_GT_BYTE 8'hff
`define RESET_LT_BYTE 8'h00
`define RESET_GROUND_SEL 1'b0
`define RESET_REF_SEL 2'h2
`define RESET_TEMP_ON 1'b0
`define RESET_BIAS_ON 1'b0

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define INPUT_CODE_MSB 4
`define REF_GND_BIT 5
`define REF_SEL_MSB 4
`define REF_SEL_LSB 3
`define REF_TEMP_BIT 2
`define REF_BIAS_BIT 1

// ----------------------------------------------------------------------------
// positive input codes
// ----------------------------------------------------------------------------
`define CODE_PORT0_LAST 5'h07
`define CODE_PORT1_LAST 5'h0f
`define CODE_TEMP 5'h10
`define CODE_VREG 5'h11
`define CODE_VDD 5'h12
`define CODE_GND 5'h13

`endif

//--- hdl/adc_ctrl_pkg.sv
// types shared by the converter control block and its window comparator;
// assumes nothing of its surroundings
package adc_ctrl_pkg;

   // ordering matches the two-bit reference select field
   typedef enum logic [1:0] {
      ref_ext_pin,
      ref_vdd,
      ref_core_supply,
      ref_hs_internal
   } ref_sel_t;

   typedef logic [9:0] conv_word_t;
   typedef logic [15:0] limit_word_t;

endpackage : adc_ctrl_pkg

//--- hdl/adc_window_mux_reference_ctrl.sv
// converter control: window detector limits and flag, positive input mux
// select, voltage and ground reference select, temperature sensor enable.
// assumes the converter presents its result word with a one-cycle done
// strobe on clk, and a special-function-register port on the same clock.
//
// Summary of operation
// - The less-than low byte is a read/write byte, reset to zero, forming the low half of the less-than limit.
// - With inside detection the flag sets when the word is above the greater-than limit and below the less-than limit.
// - With outside detection the flag sets when the word is below the greater-than limit or above the less-than limit.
// - The conversion word is compared as a 10-bit unsigned integer.
// - Codes 16 to 19 select temperature sensor, regulator output, supply and ground.
// - Reference select 0 routes the external reference pin to the converter.
// - Reference select 3 picks the internal fast reference, enabled only while the converter works.
// - Reference select 1 picks the supply and 2 picks the regulated core supply.
// - Ground select 1 takes the converter ground from the analog ground pin, else the ground pin.
// - The temperature sensor enable bit switches the sensor on.
// - The window is judged after every conversion without software help.
// - Each limit is a byte pair; greater-than bytes reset to ones, less-than bytes to zeros.
// - The window match flag can be polled.
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_consts.svh"

module adc_window_mux_reference_ctrl
   import adc_ctrl_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register port
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   // converter side
   input wire logic [9:0] conv_result,
   input wire logic conv_done,
   input wire logic conv_active,
   input wire logic window_flag_clear,
   // window detector state
   output logic window_match_flag,
   output logic window_inside_mode,
   // positive input mux
   output logic [7:0] port0_input_sel,
   output logic [7:0] port1_input_sel,
   output logic temp_input_sel,
   output logic vreg_input_sel,
   output logic vdd_input_sel,
   output logic gnd_input_sel,
   // references and sensor
   output logic vref_pin_sel,
   output logic vref_vdd_sel,
   output logic vref_core_sel,
   output logic vref_hs_sel,
   output logic hs_ref_enable,
   output logic agnd_pin_sel,
   output logic temp_sensor_on,
   output logic bias_enable
);

   // -------------------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------------------
   function automatic limit_word_t join_bytes(input logic [7:0] high, input logic [7:0] low);
      join_bytes = {high, low};
   endfunction : join_bytes

   function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
      addr_hit = (addr == target);
   endfunction : addr_hit

   // -------------------------------------------------------------------------
   // register storage
   // -------------------------------------------------------------------------
   logic [7:0] gt_limit_low_byte;
   logic [7:0] gt_limit_high_byte;
   logic [7:0] lt_limit_low_byte;
   logic [7:0] lt_limit_high_byte;
   logic [4:0] positive_input_code;
   logic ground_ref_select;
   ref_sel_t ref_voltage_select;
   logic temp_enable;
   logic bias_on;
   logic [7:0] next_rdata;

   window_if win ();

   // -------------------------------------------------------------------------
   // limit registers
   // -------------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         gt_limit_low_byte <= `RESET_GT_BYTE;
         gt_limit_high_byte <= `RESET_GT_BYTE;
      end
      else if (sfr_wr)
      begin
         if (addr_hit(sfr_addr, `ADDR_GT_LOW))
         begin
            gt_limit_low_byte <= sfr_wdata;
         end
         else if (addr_hit(sfr_addr, `ADDR_GT_HIGH))
         begin
            gt_limit_high_byte <= sfr_wdata;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lt_limit_low_byte <= `RESET_LT_BYTE;
         lt_limit_high_byte <= `RESET_LT_BYTE;
      end
      else if (sfr_wr)
      begin
         if (addr_hit(sfr_addr, `ADDR_LT_LOW))
         begin
            lt_limit_low_byte <= sfr_wdata;
         end
         else if (addr_hit(sfr_addr, `ADDR_LT_HIGH))
         begin
            lt_limit_high_byte <= sfr_wdata;
         end
      end
   end

   // -------------------------------------------------------------------------
   // input select register
   // -------------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         positive_input_code <= `RESET_INPUT_CODE;
      end
      else if (sfr_wr && addr_hit(sfr_addr, `ADDR_INPUT_SELECT))
      begin
         // upper three data bits are dropped on purpose
         positive_input_code <= sfr_wdata[`INPUT_CODE_MSB:0];
      end
   end

   // -------------------------------------------------------------------------
   // reference control register
   // -------------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ground_ref_select <= `RESET_GROUND_SEL;
         ref_voltage_select <= ref_sel_t'(`RESET_REF_SEL);
         temp_enable <= `RESET_TEMP_ON;
         bias_on <= `RESET_BIAS_ON;
      end
      else if (sfr_wr && addr_hit(sfr_addr, `ADDR_REFERENCE))
      begin
         ground_ref_select <= sfr_wdata[`REF_GND_BIT];
         ref_voltage_select <= ref_sel_t'(sfr_wdata[`REF_SEL_MSB:`REF_SEL_LSB]);
         temp_enable <= sfr_wdata[`REF_TEMP_BIT];
         bias_on <= sfr_wdata[`REF_BIAS_BIT];
      end
   end

   // -------------------------------------------------------------------------
   // read path
   // -------------------------------------------------------------------------
   always_comb
   begin
      next_rdata = 8'h00;
      if (addr_hit(sfr_addr, `ADDR_INPUT_SELECT))
      begin
         next_rdata = {3'h0, positive_input_code};
      end
      else if (addr_hit(sfr_addr, `ADDR_GT_LOW))
      begin
         next_rdata = gt_limit_low_byte;
      end
      else if (addr_hit(sfr_addr, `ADDR_GT_HIGH))
      begin
         next_rdata = gt_limit_high_byte;
      end
      else if (addr_hit(sfr_addr, `ADDR_LT_LOW))
      begin
         next_rdata = lt_limit_low_byte;
      end
      else if (addr_hit(sfr_addr, `ADDR_LT_HIGH))
      begin
         next_rdata = lt_limit_high_byte;
      end
      else if (addr_hit(sfr_addr, `ADDR_REFERENCE))
      begin
         // unused bits 7:6 and 0 read as zero
         next_rdata = {2'h0, ground_ref_select, ref_voltage_select, temp_enable, bias_on, 1'b0};
      end
   end

   // data holds between reads so a slow reader may sample late
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sfr_rdata <= 8'h00;
      end
      else if (sfr_rd)
      begin
         sfr_rdata <= next_rdata;
      end
   end

   // -------------------------------------------------------------------------
   // window detector
   // -------------------------------------------------------------------------
   assign win.result = conv_result;
   assign win.gt_limit = join_bytes(gt_limit_high_byte, gt_limit_low_byte);
   assign win.lt_limit = join_bytes(lt_limit_high_byte, lt_limit_low_byte);

   window_compare u_window_compare (
      .win (win.cmp)
   );

   // a match on the clear cycle still sets, so no event is lost
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         window_match_flag <= 1'b0;
      end
      else if (conv_done && win.hit)
      begin
         window_match_flag <= 1'b1;
      end
      else if (window_flag_clear)
      begin
         window_match_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         window_inside_mode <= 1'b0;
      end
      else
      begin
         window_inside_mode <= win.inside_mode;
      end
   end

   // -------------------------------------------------------------------------
   // positive input mux decode
   // -------------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         port0_input_sel <= 8'h00;
         port1_input_sel <= 8'h00;
      end
      else
      begin
         port0_input_sel <= 8'h00;
         port1_input_sel <= 8'h00;
         if (positive_input_code <= `CODE_PORT0_LAST)
         begin
            port0_input_sel[positive_input_code[2:0]] <= 1'b1;
         end
         else if (positive_input_code <= `CODE_PORT1_LAST)
         begin
            port1_input_sel[positive_input_code[2:0]] <= 1'b1;
         end
      end
   end

   // codes above the ground code leave every select low
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         temp_input_sel <= 1'b0;
         vreg_input_sel <= 1'b0;
         vdd_input_sel <= 1'b0;
         gnd_input_sel <= 1'b0;
      end
      else
      begin
         temp_input_sel <= (positive_input_code == `CODE_TEMP);
         vreg_input_sel <= (positive_input_code == `CODE_VREG);
         vdd_input_sel <= (positive_input_code == `CODE_VDD);
         gnd_input_sel <= (positive_input_code == `CODE_GND);
      end
   end

   // -------------------------------------------------------------------------
   // reference routing
   // -------------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         vref_pin_sel <= 1'b0;
         vref_vdd_sel <= 1'b0;
         vref_core_sel <= 1'b0;
         vref_hs_sel <= 1'b0;
      end
      else
      begin
         vref_pin_sel <= (ref_voltage_select == ref_ext_pin);
         vref_vdd_sel <= (ref_voltage_select == ref_vdd);
         vref_core_sel <= (ref_voltage_select == ref_core_supply);
         vref_hs_sel <= (ref_voltage_select == ref_hs_internal);
      end
   end

   // fast reference is powered only while selected and converting, saving
   // its bias current between conversions
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hs_ref_enable <= 1'b0;
      end
      else
      begin
         hs_ref_enable <= (ref_voltage_select == ref_hs_internal) && conv_active;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         agnd_pin_sel <= 1'b0;
         temp_sensor_on <= 1'b0;
         bias_enable <= 1'b0;
      end
      else
      begin
         agnd_pin_sel <= ground_ref_select;
         temp_sensor_on <= temp_enable;
         bias_enable <= bias_on;
      end
   end

endmodule : adc_window_mux_reference_ctrl

`default_nettype wire

//--- hdl/window_compare.sv
// window comparator: purely combinational judgement of one conversion word
// against the two limits; the caller decides when the answer counts
`timescale 1ns/1ps
`default_nettype none

module window_compare
   import adc_ctrl_pkg::*;
(
   window_if.cmp win
);

   limit_word_t word;

   // unsigned 10-bit word widened to the limit width
   assign word = {6'h00, win.result};

   // inside when the less-than limit lies above the greater-than limit
   assign win.inside_mode = (win.lt_limit > win.gt_limit);

   always_comb
   begin
      if (win.inside_mode)
      begin
         win.hit = (word > win.gt_limit) && (word < win.lt_limit);
      end
      else
      begin
         // equal limits fall here too; only a word equal to both misses
         win.hit = (word < win.gt_limit) || (word > win.lt_limit);
      end
   end

endmodule : window_compare

`default_nettype wire

//--- hdl/window_if.sv
// carrier between the control top and its window comparator;
// both ends sit on the same clock
`timescale 1ns/1ps
`default_nettype none

interface window_if;
   import adc_ctrl_pkg::*;

   conv_word_t result;
   limit_word_t gt_limit;
   limit_word_t lt_limit;
   logic inside_mode;
   logic hit;

   modport ctrl (output result, output gt_limit, output lt_limit, input inside_mode, input hit);
   modport cmp (input result, input gt_limit, input lt_limit, output inside_mode, output hit);
endinterface : window_if

`default_nettype wire
